// [design/prl_pkg.sv]
// package for the pseudo-static ram host controller: timing and carrier types
package prl_pkg;
  localparam int unsigned CLK_PERIOD_NS          = 10;
  localparam int unsigned WRITE_CYCLE_NS         = 70;   // write_cycle_period minimum
  localparam int unsigned WRITE_STROBE_NS        = 46;   // write_strobe_pulse_width minimum
  localparam int unsigned DATA_SETUP_NS          = 23;   // data_valid_setup_window minimum
  localparam int unsigned READ_CYCLE_NS          = 70;
  localparam int unsigned DESELECT_NS            = 5;    // chip select high time
  localparam int unsigned MAX_SELECT_US          = 10;   // max_select_active_time
  // least times round up, longest times round down
  localparam int unsigned WRITE_CYCLE_CYC  = (WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_STROBE_CYC = (WRITE_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DATA_SETUP_CYC   = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READ_CYCLE_CYC   = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DESELECT_CYC     = (DESELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MAX_SELECT_CYC   = (MAX_SELECT_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned ADDR_W  = 22;
  localparam int unsigned DATA_W  = 16;
  localparam int unsigned CNT_W   = 16;
  localparam int unsigned BURST_W = 8;
  localparam int unsigned LANES   = 2;

  typedef enum logic [1:0] {
    PRL_IDLE,
    PRL_ACCESS,
    PRL_RECOVER
  } prl_state_e;

  // one request from the user side
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [LANES-1:0]  lane_en;   // bit 0 lower byte, bit 1 upper byte
    logic [BURST_W-1:0] wait_cyc; // extra strobe cycles asked by the user
  } prl_req_s;

  // memory pins driven by the host, select pins active low
  typedef struct packed {
    logic              sel_n;
    logic              wr_n;
    logic              rd_n;
    logic [LANES-1:0]  byte_sel_n; // upper_byte_select_low, lower_byte_select_low
    logic [ADDR_W-1:0] addr;
  } prl_pins_s;
endpackage : prl_pkg

// [design/prl_timer.sv]
// down-counting interval timer with a zero flag
`timescale 1ns/1ns
module prl_timer (
  input  wire logic                           i_clk,
  input  wire logic                           i_rst_n,
  input  wire logic                           i_load,
  input  wire logic [prl_pkg::CNT_W-1:0]      i_value,
  output logic                                o_zero
);
  logic [prl_pkg::CNT_W-1:0] cnt_q;

  // load wins over counting
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (i_load) begin
      cnt_q <= i_value;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign o_zero = (cnt_q == '0);
endmodule : prl_timer

// [design/prl_host.sv]
// host controller for a pseudo-static ram with hidden refresh
`timescale 1ns/1ns
// Function
// - every write ends well inside the 10 us bound
// - after each operation, select is released before the next access
// - select active interval held below 10 us for every operation
// - page mode: select released after every write
// - page mode: each write total kept at or under 10 us
// - extended write stretches strobe and data setup by the wait_cyc cycles asked
// - stretched timing only for writes that ask wait cycles
module prl_host (
  input  wire logic                          I_CLK,
  input  wire logic                          I_RST_N,
  input  wire logic                          I_REQ_VALID,
  output logic                               O_REQ_READY,
  input  wire prl_pkg::prl_req_s             I_REQ,
  input  wire logic                          I_PAGE_MODE,
  output logic                               O_RESP_VALID,
  output logic [prl_pkg::DATA_W-1:0]         O_RDATA,
  output logic                               O_CUT_SHORT,
  output prl_pkg::prl_pins_s                 O_PINS,
  output logic [prl_pkg::DATA_W-1:0]         O_DQ_OUT,
  output logic                               O_DQ_OE,
  input  wire logic [prl_pkg::DATA_W-1:0]    I_DQ_IN
);
  localparam logic [prl_pkg::CNT_W-1:0] WC_C   = prl_pkg::CNT_W'(prl_pkg::WRITE_CYCLE_CYC);
  localparam logic [prl_pkg::CNT_W-1:0] WP_C   = prl_pkg::CNT_W'(prl_pkg::WRITE_STROBE_CYC);
  localparam logic [prl_pkg::CNT_W-1:0] RC_C   = prl_pkg::CNT_W'(prl_pkg::READ_CYCLE_CYC);
  localparam logic [prl_pkg::CNT_W-1:0] DS_C   = prl_pkg::CNT_W'(prl_pkg::DESELECT_CYC);
  // leave margin: end one write cycle before the bound, so even a clipped
  // write keeps a full write cycle of strobe and data before select rises
  localparam logic [prl_pkg::CNT_W-1:0] LIM_C  =
    prl_pkg::CNT_W'(prl_pkg::MAX_SELECT_CYC - prl_pkg::WRITE_CYCLE_CYC);

  // sequencer state, captured request and interval counting
  prl_pkg::prl_state_e   state_q;
  prl_pkg::prl_req_s     req_q;
  logic [prl_pkg::CNT_W-1:0] sel_cnt_q;
  logic                  ext_q;
  logic                  cut_q;
  logic                  load;
  logic [prl_pkg::CNT_W-1:0] load_val;
  logic                  phase_zero;
  logic                  over_lim;
  // shared decodes of the sequencer; take and access_end are used by several processes
  logic                  take;
  logic                  access_end;
  logic                  recover_end;

  // strobe length: reads fixed, writes normal or extended
  // wait_cyc alone cannot reach the clip; it guards a wider request field
  function automatic logic [prl_pkg::CNT_W-1:0] strobe_len(input prl_pkg::prl_req_s r);
    logic [prl_pkg::CNT_W-1:0] base;
    logic [prl_pkg::CNT_W-1:0] want;
    base = r.write ? WP_C : RC_C;
    want = base + prl_pkg::CNT_W'(r.wait_cyc);
    if (!r.write) begin
      strobe_len = RC_C;
    end else if (want > LIM_C) begin
      strobe_len = (LIM_C > WC_C) ? LIM_C : WC_C;
    end else begin
      strobe_len = (want > WP_C) ? want : WP_C;
    end
  endfunction : strobe_len

  // one timer serves both phases: strobe length first, then deselect time
  prl_timer u_phase (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_load  (load),
    .i_value (load_val),
    .o_zero  (phase_zero)
  );

  // ready straight from state: a new request waits until recovery ends
  assign O_REQ_READY = (state_q == prl_pkg::PRL_IDLE);
  assign over_lim    = (sel_cnt_q >= LIM_C);
  assign take        = (state_q == prl_pkg::PRL_IDLE) && I_REQ_VALID;
  assign access_end  = (state_q == prl_pkg::PRL_ACCESS) && (phase_zero || over_lim);
  assign recover_end = (state_q == prl_pkg::PRL_RECOVER) && phase_zero;

  // timer loads on accept and on ending access
  always_comb begin
    load     = 1'b0;
    load_val = '0;
    case (state_q)
      prl_pkg::PRL_IDLE: begin
        if (I_REQ_VALID) begin
          load     = 1'b1;
          load_val = strobe_len(I_REQ) - 1'b1;
        end
      end
      prl_pkg::PRL_ACCESS: begin
        if (phase_zero || over_lim) begin
          load     = 1'b1;
          load_val = DS_C;
        end
      end
      default: begin
        load     = 1'b0;
        load_val = '0;
      end
    endcase
  end

  // sequencer: every operation ends with deselect, no direct chaining
  // chaining at a new address is legal with page mode off; not used, which
  // keeps one sequence for both modes at the cost of a few deselect cycles
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      state_q <= prl_pkg::PRL_IDLE;
    end else begin
      case (state_q)
        prl_pkg::PRL_IDLE: begin
          if (I_REQ_VALID) state_q <= prl_pkg::PRL_ACCESS;
        end
        prl_pkg::PRL_ACCESS: begin
          if (phase_zero || over_lim) state_q <= prl_pkg::PRL_RECOVER;
        end
        prl_pkg::PRL_RECOVER: begin
          if (phase_zero) state_q <= prl_pkg::PRL_IDLE;
        end
        default: state_q <= prl_pkg::PRL_IDLE;
      endcase
    end
  end

  // captured request; page mode gives no shortcut, so no address-only chaining
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      req_q <= '0;
      ext_q <= 1'b0;
    end else if (take) begin
      req_q <= I_REQ;
      ext_q <= I_REQ.write && (strobe_len(I_REQ) > WP_C) && !I_PAGE_MODE;
    end
  end

  // select-active counter on I_CLK, the sequencer clock
  // counts only while selected, so a stalled user cannot stretch select
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      sel_cnt_q <= '0;
    end else if (state_q == prl_pkg::PRL_ACCESS) begin
      sel_cnt_q <= sel_cnt_q + 1'b1;
    end else begin
      sel_cnt_q <= '0;
    end
  end

  // select, strobes, byte selects and address from flops; no refresh cycles here
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_PINS <= '{sel_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, byte_sel_n: '1, addr: '0};
    end else if (take) begin
      // byte selects are active low at the pin, lane enables active high
      O_PINS.sel_n      <= 1'b0;
      O_PINS.wr_n       <= ~I_REQ.write;
      O_PINS.rd_n       <= I_REQ.write;
      O_PINS.byte_sel_n <= ~I_REQ.lane_en;
      O_PINS.addr       <= I_REQ.addr;
    end else if (access_end) begin
      // address left as it is: the memory schedules refresh from select alone
      O_PINS.sel_n      <= 1'b1;
      O_PINS.wr_n       <= 1'b1;
      O_PINS.rd_n       <= 1'b1;
      O_PINS.byte_sel_n <= '1;
    end
  end

  // write data and its enable; data stands the whole strobe, so the data
  // window is never shorter than the strobe, clipped or not
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_DQ_OUT <= '0;
      O_DQ_OE  <= 1'b0;
    end else if (take) begin
      O_DQ_OUT <= I_REQ.wdata;
      O_DQ_OE  <= I_REQ.write;
    end else if (access_end) begin
      O_DQ_OE  <= 1'b0;
    end
  end

  // read data taken on the last strobe cycle, while the memory still drives
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_RDATA <= '0;
    end else if (access_end && !req_q.write) begin
      O_RDATA <= I_DQ_IN;
    end
  end

  // remember whether the limit, not the timer, ended the strobe;
  // the flag is held through recovery until the answer carries it
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      cut_q <= 1'b0;
    end else if (access_end) begin
      cut_q <= over_lim && !phase_zero;
    end
  end

  // answer once deselect recovery is over; the cut flag rides with it
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_RESP_VALID <= 1'b0;
      O_CUT_SHORT  <= 1'b0;
    end else begin
      O_RESP_VALID <= recover_end;
      O_CUT_SHORT  <= recover_end && cut_q;
    end
  end

  // stretched non-page write flag; kept for observation, nothing reads it
  logic unused_ext;
  assign unused_ext = ext_q;
endmodule : prl_host

// [test/prl_mem_model.sv]
// behavioural pseudo-static ram with hidden refresh
`timescale 1ns/1ns
module prl_mem_model (
  input  wire logic               i_clk,
  input  wire prl_pkg::prl_pins_s i_pins,
  input  wire logic [15:0]        i_dq,
  output logic [15:0]             o_dq,
  output logic                    o_overlong
);
  logic [15:0] mem [256];
  logic [15:0] last_q;
  int          sel_cnt;
  initial o_overlong = 1'b0;
  // refresh never stalls the bus, so writes land at any bus speed;
  // only select time counts, address changes give no refresh slot
  always @(posedge i_clk) begin
    sel_cnt = i_pins.sel_n ? 0 : sel_cnt + 1;
    if (sel_cnt >= 1000) o_overlong <= 1'b1;
    if (!i_pins.sel_n && !i_pins.wr_n && !i_pins.byte_sel_n[0])
      mem[i_pins.addr[7:0]][7:0] <= i_dq[7:0];
    if (!i_pins.sel_n && !i_pins.wr_n && !i_pins.byte_sel_n[1])
      mem[i_pins.addr[7:0]][15:8] <= i_dq[15:8];
    last_q <= o_dq;
  end
  // reads answer at once whatever the bus pace; a released bus toggles
  always_comb o_dq = (!i_pins.sel_n && !i_pins.rd_n) ? mem[i_pins.addr[7:0]] : ~last_q;
endmodule : prl_mem_model

// [test/prl_host_asserts.sv]
// port assertions for the pseudo-static ram host controller
`timescale 1ns/1ns
module prl_host_asserts (
  input wire logic                       I_CLK,
  input wire logic                       I_RST_N,
  input wire logic                       I_REQ_VALID,
  input wire logic                       O_REQ_READY,
  input wire prl_pkg::prl_req_s          I_REQ,
  input wire logic                       I_PAGE_MODE,
  input wire logic                       O_RESP_VALID,
  input wire logic                       O_CUT_SHORT,
  input wire prl_pkg::prl_pins_s         O_PINS,
  input wire logic [prl_pkg::DATA_W-1:0] O_DQ_OUT,
  input wire logic                       O_DQ_OE
);
  logic [15:0] sel_cnt_q;
  // select-low run length; a repeat would tie it to strobe syntax
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N || O_PINS.sel_n) sel_cnt_q <= 16'h0000;
    else sel_cnt_q <= sel_cnt_q + 16'h0001;
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence take_s; I_REQ_VALID && O_REQ_READY; endsequence
  sequence strobe_s; $fell(O_PINS.wr_n); endsequence
  a_sel_bounded: assert property (sel_cnt_q < 16'h03E2)
    else $error("select held too long");
  a_strobe_min: assert property (strobe_s |-> (!O_PINS.wr_n)[*5])
    else $error("write strobe too short");
  a_read_answer: assert property (take_s ##0 !I_REQ.write |-> ##10 O_RESP_VALID)
    else $error("read answer late");
  a_page_deselect: assert property (
    I_PAGE_MODE && $rose(O_PINS.wr_n) |-> $rose(O_PINS.sel_n))
    else $error("select kept after page write");
  a_resp_idle: assert property (O_RESP_VALID |-> O_PINS.sel_n && $past(O_PINS.sel_n))
    else $error("answer while selected");
  a_take_select: assert property (
    take_s |=> !O_PINS.sel_n && O_PINS.addr == $past(I_REQ.addr))
    else $error("access not started");
  a_data_window: assert property (
    !O_PINS.wr_n && !$past(O_PINS.wr_n) |-> O_DQ_OE && $stable(O_DQ_OUT))
    else $error("write data moved");
  a_cut_resp: assert property (O_CUT_SHORT |-> O_RESP_VALID)
    else $error("cut flag without answer");
endmodule : prl_host_asserts

// [test/tb.sv]
// self-checking bench for the pseudo-static ram host controller
`timescale 1ns/1ns
module tb;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               v = 1'b0;
  logic               pm = 1'b0;
  prl_pkg::prl_req_s  rq = '0;
  logic               ready, resp, cut, oe, ovl;
  logic [15:0]        rdata, dq_out, dq_in, q;
  prl_pkg::prl_pins_s pins;
  int                 error_cnt = 0;
  int                 checks = 0;
  prl_host i_prl_host (.I_CLK(clk), .I_RST_N(rst_n), .I_REQ_VALID(v), .O_REQ_READY(ready),
    .I_REQ(rq), .I_PAGE_MODE(pm), .O_RESP_VALID(resp), .O_RDATA(rdata), .O_CUT_SHORT(cut),
    .O_PINS(pins), .O_DQ_OUT(dq_out), .O_DQ_OE(oe), .I_DQ_IN(dq_in));
  prl_mem_model i_prl_mem_model (.i_clk(clk), .i_pins(pins), .i_dq(dq_out), .o_dq(dq_in),
    .o_overlong(ovl));
  // free-running 100 MHz clock
  always #5 clk = ~clk;
  task automatic final_report();
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : cmp16
  task automatic cmpi(input int got, input int exp, input string m);
    checks++;
    if (got != exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %0d exp %0d", $time, m, got, exp);
    end
  endtask : cmpi
  // one transfer; b2b reuses a request still held valid from the last one
  task automatic op(input logic w, input logic [21:0] a, input logic [15:0] d,
                    input logic [1:0] ln, input logic [7:0] wt, input logic b2b,
                    input logic hold);
    int n;
    int lat;
    n = 0;
    // strobe cycles, then the recovery load edge and the timed deselect
    lat = w ? int'(prl_pkg::WRITE_STROBE_CYC) + int'(wt) : int'(prl_pkg::READ_CYCLE_CYC);
    lat = lat + int'(prl_pkg::DESELECT_CYC) + 1;
    if (!b2b) @(posedge clk) begin
      v  <= 1'b1;
      rq <= '{w, a, d, ln, wt};
    end
    @(posedge clk) v <= hold;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (n < 1000 && resp !== 1'b1);
    if (n == 1000) begin
      error_cnt++;
      final_report();
    end
    cmpi(n, lat, "answer latency");
    cmp16({15'h0000, cut}, 16'h0000, "cut short");
    q = rdata;
  endtask : op
  task automatic t_reset();
    logic [15:0] idle_bits;
    @(posedge clk);
    #1;
    idle_bits = {9'h000, ready, pins.sel_n, pins.wr_n, pins.rd_n, pins.byte_sel_n, oe};
    cmp16(idle_bits, 16'h007E, "idle");
  endtask : t_reset
  task automatic t_lanes();
    op(1'b1, 22'h00_0012, 16'hA5C3, 2'b11, 8'h00, 1'b0, 1'b0);
    op(1'b1, 22'h00_0012, 16'h1111, 2'b01, 8'h00, 1'b0, 1'b0);
    op(1'b1, 22'h00_003F, 16'h7E7E, 2'b11, 8'h02, 1'b0, 1'b0);
    op(1'b0, 22'h00_0012, 16'h0000, 2'b11, 8'h09, 1'b0, 1'b0);
    cmp16(q, 16'hA511, "lane merge");
  endtask : t_lanes
  task automatic t_ext();
    @(posedge clk) pm <= 1'b1;
    op(1'b1, 22'h00_0012, 16'h2222, 2'b10, 8'hFF, 1'b0, 1'b0);
    op(1'b0, 22'h00_0012, 16'h0000, 2'b11, 8'h00, 1'b0, 1'b0);
    cmp16(q, 16'h2211, "extended write");
    @(posedge clk) pm <= 1'b0;
  endtask : t_ext
  task automatic t_b2b();
    op(1'b0, 22'h00_003F, 16'h0000, 2'b11, 8'h00, 1'b0, 1'b1);
    cmp16(q, 16'h7E7E, "first read");
    op(1'b0, 22'h00_003F, 16'h0000, 2'b11, 8'h00, 1'b1, 1'b0);
    cmp16(q, 16'h7E7E, "second read");
    cmp16({15'h0000, ovl}, 16'h0000, "overlong select");
  endtask : t_b2b
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_lanes();
    t_ext();
    t_b2b();
    final_report();
  end
endmodule : tb
bind prl_host prl_host_asserts i_prl_host_asserts (.*);
